//--- irt_isa_dev.sv
// Model of an ISA I/O peripheral cycle run by the sequencer
`timescale 1ns/1ps
module irt_isa_dev
    import irt_pkg::*;
(
    // Clock and reset
    input  wire logic   ref_clk,
    input  wire logic   rst,
    // Start request from the bench
    input  wire logic   go,
    input  wire logic   go_wide,
    // Recovery link
    input  wire logic   io_ready8,
    input  wire logic   io_ready16,
    output irt_done_type io_done
);
    logic [1:0] busy_reg;   // Cycles left in the current ISA cycle
    logic       wide_reg;   // Width of the current cycle
    // A cycle takes two clocks, then reports completion for one clock
    always_ff @(posedge ref_clk) begin
        io_done <= '0;
        if (rst) begin
            busy_reg <= 2'h0;
        end else if (busy_reg != 2'h0) begin
            busy_reg <= busy_reg - 2'h1;
            if (busy_reg == 2'h1) begin
                io_done <= '{valid: 1'b1, wide: wide_reg};
            end
        end else if (go && (go_wide ? io_ready16 : io_ready8)) begin
            // Never start while the counter for this width is still recovering
            busy_reg <= 2'h2;
            wide_reg <= go_wide;
        end
    end
endmodule

//--- irt_monitor.sv
// Checker for recovery timing and the ISA clock
`timescale 1ns/1ps
module irt_monitor
    import irt_pkg::*;
(
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // Recovery link and ISA clock
    input  wire irt_done_type io_done,
    input  wire logic         io_ready8,
    input  wire logic         io_ready16,
    input  wire logic         isa_clk,
    input  wire logic         isa_clk_rise
);
    logic [4:0] lo8_reg;    // Clocks since the last 8-bit completion
    logic [4:0] lo16_reg;   // Clocks since the last 16-bit completion
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Counting from completion exposes a missing fixed clock
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lo8_reg  <= 5'h00;
            lo16_reg <= 5'h00;
        end else begin
            lo8_reg  <= (io_done.valid && !io_done.wide) ? 5'h01 : lo8_reg + {4'h0, !io_ready8};
            lo16_reg <= (io_done.valid && io_done.wide) ? 5'h01 : lo16_reg + {4'h0, !io_ready16};
        end
    end
    drop8_a: assert property (io_done.valid && !io_done.wide |=> !io_ready8)
        else $error("8-bit ready did not drop");
    drop16_a: assert property (io_done.valid && io_done.wide |=> !io_ready16)
        else $error("16-bit ready did not drop");
    min8_a: assert property ($rose(io_ready8) |-> lo8_reg >= 5'h03)
        else $error("8-bit recovery too short");
    max8_a: assert property ($rose(io_ready8) |-> lo8_reg <= 5'h12)
        else $error("8-bit recovery too long");
    span16_a: assert property ($rose(io_ready16) |-> lo16_reg inside {[5'h03:5'h12]})
        else $error("16-bit recovery out of range");
    high_two_a: assert property ($rose(isa_clk) |-> isa_clk [*2] ##1 !isa_clk)
        else $error("ISA clock high time wrong");
    low_span_a: assert property ($fell(isa_clk) |-> ##[1:2] isa_clk)
        else $error("ISA clock low time wrong");
    rise_mark_a: assert property (isa_clk_rise == $rose(isa_clk))
        else $error("ISA clock rise pulse misplaced");
    cover property ($rose(io_ready8));
    cover property ($rose(io_ready16));
    cover property ($fell(isa_clk) ##1 isa_clk);
endmodule
bind irt_recovery irt_monitor i_mon (.ref_clk(ref_clk), .rst(rst), .io_done(io_done),
    .io_ready8(io_ready8), .io_ready16(io_ready16), .isa_clk(isa_clk),
    .isa_clk_rise(isa_clk_rise));

//--- irt_pkg.sv
// Package for the ISA I/O recovery timing block
package irt_pkg;

    // Register indices, byte address is four times the index
    localparam logic [7:0]  IRT_IDX_DIV    = 8'h50;
    localparam logic [7:0]  IRT_IDX_RECOV  = 8'h51;
    localparam logic [7:0]  IRT_IDX_STAT   = 8'h60;

    // Reset values
    localparam logic [7:0]  IRT_RST_RECOV  = 8'h43;
    localparam logic [2:0]  IRT_RST_DIV    = 3'h3;

    // Field positions in the recovery register
    localparam int          IRT_R8_LSB     = 4;
    localparam int          IRT_R16_LSB    = 0;
    localparam int          IRT_RFLD_W     = 4;

    // Field positions in the divisor register
    localparam int          IRT_DIV_LSB    = 0;
    localparam int          IRT_DIV_W      = 3;

    // Status register bit positions
    localparam int          IRT_ST_BUSY8   = 0;
    localparam int          IRT_ST_BUSY16  = 1;
    localparam int          IRT_ST_ISACLK  = 2;

    // Divisor codes and their divide ratios
    localparam logic [2:0]  IRT_DIV_CODE3  = 3'h2;
    localparam logic [2:0]  IRT_DIV_CODE4  = 3'h3;
    localparam logic [2:0]  IRT_RATIO3     = 3'h3;
    localparam logic [2:0]  IRT_RATIO4     = 3'h4;

    // Fixed built-in delay plus the one clock of code zero
    localparam logic [4:0]  IRT_FIXED_DLY  = 5'h1;
    localparam logic [4:0]  IRT_CODE_BIAS  = 5'h1;

    // AHB transfer type bit for an active transfer
    localparam int          IRT_HTRANS_ACT = 1;

    // Completed ISA I/O cycle event
    typedef struct packed {
        logic valid;    // One-cycle completion pulse
        logic wide;     // High for a 16-bit cycle
    } irt_done_type;

    // Latched AHB address phase
    typedef struct packed {
        logic       write;  // Write transfer
        logic       read;   // Read transfer
        logic [7:0] index;  // Word index
    } irt_aphase_type;

endpackage

//--- irt_recovery.sv
// ISA I/O recovery timing and ISA clock divider with AHB-Lite registers
`timescale 1ns/1ps

module irt_recovery
    import irt_pkg::*;
#(
    parameter int CNT_W = 5     // Recovery counter width
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // AHB-Lite slave
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic [31:0]       hrdata,
    output logic              hresp,
    // ISA cycle sequencer side
    input  wire irt_done_type io_done,
    output logic              io_ready8,
    output logic              io_ready16,
    // ISA bus clock
    output logic              isa_clk,
    output logic              isa_clk_rise
);

    // Widest load is 15 + 1 + 1 = 17, which needs five bits.
    // A narrower counter would wrap the longest code to a short
    // gap and let the next cycle start far too early.
    initial begin
        if (CNT_W < 5) begin
            $error("CNT_W must be at least 5");
        end
    end

    // Register state
    logic [7:0]     recov_reg;      // Recovery control
    logic [7:0]     recov_next;
    logic [2:0]     div_reg;        // ISA clock divisor code
    logic [2:0]     div_next;
    irt_aphase_type aph_reg;        // Pending data phase
    irt_aphase_type aph_next;
    logic [31:0]    rdata_reg;      // Read data
    logic [31:0]    rdata_next;

    // Recovery counters, index 0 for 8-bit, 1 for 16-bit
    logic [CNT_W-1:0] cnt_reg  [2];
    logic [CNT_W-1:0] cnt_next [2];

    // Divider state
    logic [2:0]     phase_reg;      // Position in ISA clock period
    logic [2:0]     phase_next;
    logic           isa_reg;        // ISA clock level
    logic           isa_next;
    logic           rise_reg;       // Rising edge marker
    logic           rise_next;

    // Address phase accepted this cycle
    logic           take;
    logic [7:0]     idx;

    // Byte address to word index, shared by write and read paths
    function automatic logic [7:0] word_index(input logic [31:0] a);
        word_index = a[9:2];
    endfunction

    // Map a divisor code to its ratio; a bad code falls back to four
    function automatic logic [2:0] div_ratio(input logic [2:0] code);
        if (code == IRT_DIV_CODE3) begin
            div_ratio = IRT_RATIO3;
        end else begin
            div_ratio = IRT_RATIO4;
        end
    endfunction

    // Decode a recovery field into a full hold-off count
    function automatic logic [CNT_W-1:0] recov_load(
        input logic [IRT_RFLD_W-1:0] fld
    );
        logic [4:0] sum;
        sum = 5'(fld) + IRT_CODE_BIAS + IRT_FIXED_DLY;
        recov_load = CNT_W'(sum);
    endfunction

    // Zero wait states and an OKAY answer on every transfer.
    // Every register is a plain flop, so there is nothing that
    // could ever need a stretched data phase or an error answer.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_reg;

    // Address phase decode
    assign take = hsel & hready & htrans[IRT_HTRANS_ACT];
    assign idx  = word_index(haddr);

    // Bus next-state: latch the address phase
    always_comb begin
        aph_next = '0;
        if (take) begin
            aph_next.write = hwrite;
            aph_next.read  = ~hwrite;
            aph_next.index = idx;
        end
    end

    // Register writes land in the data phase
    always_comb begin
        recov_next = recov_reg;
        div_next   = div_reg;
        if (aph_reg.write) begin
            if (aph_reg.index == IRT_IDX_RECOV) begin
                // Both nibbles are written as one byte
                recov_next = hwdata[7:0];
            end else if (aph_reg.index == IRT_IDX_DIV) begin
                // Code is stored as written, checked at use
                div_next = hwdata[IRT_DIV_LSB +: IRT_DIV_W];
            end
        end
    end

    // Read data is built from next values so a read right
    // behind a write to the same word sees the new contents
    always_comb begin
        rdata_next = '0;
        if (take && !hwrite) begin
            if (idx == IRT_IDX_RECOV) begin
                rdata_next[7:0] = recov_next;
            end else if (idx == IRT_IDX_DIV) begin
                rdata_next[IRT_DIV_LSB +: IRT_DIV_W] = div_next;
            end else if (idx == IRT_IDX_STAT) begin
                rdata_next[IRT_ST_BUSY8]  = (cnt_next[0] != '0);
                rdata_next[IRT_ST_BUSY16] = (cnt_next[1] != '0);
                rdata_next[IRT_ST_ISACLK] = isa_next;
            end
            // Unmapped words read as zero
        end
    end

    // Bus and configuration registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            recov_reg <= IRT_RST_RECOV;
            div_reg   <= IRT_RST_DIV;
            aph_reg   <= '0;
            rdata_reg <= '0;
        end else begin
            recov_reg <= recov_next;
            div_reg   <= div_next;
            aph_reg   <= aph_next;
            rdata_reg <= rdata_next;
        end
    end

    // One recovery counter per transfer width
    for (genvar w = 0; w < 2; w++) begin : g_recov
        logic [IRT_RFLD_W-1:0] fld;     // Field for this width
        logic                  hit;     // Completion of this width

        // 8-bit uses the upper nibble, 16-bit the lower
        assign fld = (w == 0) ? recov_reg[IRT_R8_LSB +: IRT_RFLD_W]
                              : recov_reg[IRT_R16_LSB +: IRT_RFLD_W];
        assign hit = io_done.valid & (io_done.wide == (w == 1));

        // A completion reloads the count even mid-recovery,
        // so the gap is always measured from the last cycle
        always_comb begin
            cnt_next[w] = cnt_reg[w];
            if (hit) begin
                cnt_next[w] = recov_load(fld);
            end else if (cnt_reg[w] != '0) begin
                cnt_next[w] = cnt_reg[w] - 1'b1;
            end
        end

        // Counter register
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                cnt_reg[w] <= '0;
            end else begin
                cnt_reg[w] <= cnt_next[w];
            end
        end
    end

    // Next cycle of a width may start only once its count drains
    assign io_ready8  = (cnt_reg[0] == '0);
    assign io_ready16 = (cnt_reg[1] == '0);

    // ISA clock divider next-state
    always_comb begin
        logic [2:0] ratio;
        ratio      = div_ratio(div_reg);
        // A shortened ratio can leave phase past the end; wrap it
        if (phase_reg >= ratio - 3'h1) begin
            phase_next = '0;
        end else begin
            phase_next = phase_reg + 3'h1;
        end
        // High for the first half, rounded up for divide by three
        isa_next  = (phase_next < ((ratio + 3'h1) >> 1));
        rise_next = (phase_next == '0);
    end

    // Divider registers; outputs come straight from flops.
    // Phase resets to the last step of a divide-by-four period, so
    // the first clock out of reset opens a period: the ISA clock
    // then rises together with its rise marker, never without it.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase_reg <= IRT_RATIO4 - 3'h1;
            isa_reg   <= 1'b0;
            rise_reg  <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            isa_reg   <= isa_next;
            rise_reg  <= rise_next;
        end
    end

    // ISA clock outputs; the rise marker lets the sequencer align
    // its strobes to the ISA clock without an edge detector of its own
    assign isa_clk      = isa_reg;
    assign isa_clk_rise = rise_reg;

    // The bus signals hsize and upper address bits are not
    // checked: only whole-word single transfers are expected
    logic unused_ok;
    assign unused_ok = ^{hsize, haddr[31:10], haddr[1:0], hwdata[31:8]};

endmodule

//--- test_isa_io_recovery_timing.sv
// Testbench for the ISA I/O recovery timing block
`timescale 1ns/1ps
module test_isa_io_recovery_timing
    import irt_pkg::*;
;
    logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, go = 1'b0, go_wide = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        hready, hresp, io_ready8, io_ready16, isa_clk, isa_clk_rise;
    logic        hreadyout;
    irt_done_type io_done;
    int err_total = 0, num_checks = 0;
    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;
    irt_recovery i_dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .io_done(io_done),
        .io_ready8(io_ready8), .io_ready16(io_ready16), .isa_clk(isa_clk),
        .isa_clk_rise(isa_clk_rise));
    irt_isa_dev i_dev (.ref_clk(ref_clk), .rst(rst), .go(go), .go_wide(go_wide),
        .io_ready8(io_ready8), .io_ready16(io_ready16), .io_done(io_done));
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One word transfer: address phase, then data phase
    task ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge ref_clk);
        hsel <= 1'b1; haddr <= {22'h0, idx, 2'b00}; htrans <= 2'h2; hwrite <= wr;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd = hrdata;
        chk("response", 32'h0, {31'h0, hresp});
    endtask
    task t_regs;
        ahb(1'b0, IRT_IDX_RECOV, '0); chk("recovery reset", 32'h43, rd);
        ahb(1'b0, IRT_IDX_DIV, '0); chk("divisor reset", 32'h3, rd);
        ahb(1'b1, IRT_IDX_RECOV, 32'hA5); ahb(1'b0, IRT_IDX_RECOV, '0);
        chk("recovery readback", 32'hA5, rd);
        ahb(1'b0, IRT_IDX_STAT, '0); chk("idle status", 32'h0, rd & 32'h3);
        ahb(1'b0, 8'h7F, '0); chk("unmapped read", 32'h0, rd);
        $display("register test done");
    endtask
    // Run one cycle of a width and count the clocks from its completion until its ready returns
    task t_recov(input logic [3:0] n, input logic w);
        int k, lo;
        ahb(1'b1, IRT_IDX_RECOV, {24'h0, n, n});
        @(posedge ref_clk); go <= 1'b1; go_wide <= w;
        @(posedge ref_clk); go <= 1'b0;
        k = 0; lo = 0;
        do begin @(posedge ref_clk); #1; k++; end while (io_done.valid !== 1'b1 && k < 20);
        do begin @(posedge ref_clk); #1; lo++; end while ((w ? io_ready16 : io_ready8) !== 1'b1
            && lo < 40);
        chk(w ? "16-bit recovery" : "8-bit recovery", 32'(n) + 32'd3, 32'(lo));
    endtask
    // Status shows the 8-bit count busy right after a cycle, idle later
    task t_stat;
        int k;
        ahb(1'b1, IRT_IDX_RECOV, 32'hF0);
        @(posedge ref_clk); go <= 1'b1; go_wide <= 1'b0;
        @(posedge ref_clk); go <= 1'b0;
        k = 0;
        do begin @(posedge ref_clk); #1; k++; end while (io_done.valid !== 1'b1 && k < 20);
        ahb(1'b0, IRT_IDX_STAT, '0); chk("busy status", 32'h1, rd & 32'h3);
        repeat (20) @(posedge ref_clk);
        ahb(1'b0, IRT_IDX_STAT, '0); chk("drained status", 32'h0, rd & 32'h3);
        $display("status test done");
    endtask
    // Measure the ISA clock period after a divisor write
    task t_div(input logic [2:0] c, input int p);
        int k;
        ahb(1'b1, IRT_IDX_DIV, {29'h0, c});
        repeat (2) begin
            k = 0;
            do begin @(posedge ref_clk); #1; k++; end while (isa_clk_rise !== 1'b1 && k < 10);
        end
        chk("ISA clock period", 32'(p), 32'(k));
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Cut a hang short well beyond the expected run
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_recov(4'h0, 1'b0); t_recov(4'hF, 1'b0); t_recov(4'hD, 1'b1);
        t_recov(4'h0, 1'b1); t_recov(4'hE, 1'b1); t_recov(4'hF, 1'b1);
        $display("recovery test done");
        t_stat();
        t_div(3'h2, 3); t_div(3'h3, 4);
        $display("divisor test done");
        print_verdict();
    end
endmodule
